// *** hsst_pkg.sv ***
// Constants, types and decode functions for the high-side switch timer control block.
package hsst_pkg;

	// Register offsets on the serial register port.
	localparam logic [6:0] HSST_ADDR_TIMER_B = 7'h0D;
	localparam logic [6:0] HSST_ADDR_SHUTDOWN = 7'h10;
	localparam logic [6:0] HSST_ADDR_CONFIG_1 = 7'h14;
	localparam logic [6:0] HSST_ADDR_CONFIG_2 = 7'h15;

	// Field positions of the timer, switch and shutdown registers, and reset values.
	localparam int HSST_HI_LSB = 4;
	localparam int HSST_LO_LSB = 0;
	localparam int HSST_BIT_OV_DIS = 6;
	localparam int HSST_BIT_UV_DIS = 5;
	localparam int HSST_BIT_REC = 4;
	localparam logic [7:0] HSST_RESET_VALUE = 8'h00;
	localparam logic [2:0] HSST_FIELD_RESET = 3'h0;

	// Switch source codes.
	localparam logic [2:0] HSST_SRC_OFF = 3'h0;
	localparam logic [2:0] HSST_SRC_ON = 3'h1;
	localparam logic [2:0] HSST_SRC_TIMER_A = 3'h2;
	localparam logic [2:0] HSST_SRC_TIMER_B = 3'h3;
	localparam logic [2:0] HSST_SRC_PWM_A = 3'h4;
	localparam logic [2:0] HSST_SRC_PWM_B = 3'h5;

	// On-time and period codes with special meaning.
	localparam logic [2:0] HSST_ON_LOW = 3'h0;
	localparam logic [2:0] HSST_ON_HIGH = 3'h6;
	localparam logic [2:0] HSST_ON_RSVD = 3'h7;
	localparam logic [2:0] HSST_PER_RSVD = 3'h7;

	// Clock and base tick of the timer, in their own units.
	localparam int HSST_CLK_PS = 8000;
	localparam int HSST_TICK_US = 10;
	localparam int HSST_TICK_CYC = HSST_TICK_US * 1000000 / HSST_CLK_PS;
	localparam int HSST_DIV_W = 16;
	localparam int HSST_CNT_W = 18;

	// On-times and periods in microseconds.
	localparam int HSST_ON_US_1 = 100;
	localparam int HSST_ON_US_2 = 300;
	localparam int HSST_ON_US_3 = 1000;
	localparam int HSST_ON_US_4 = 10000;
	localparam int HSST_ON_US_5 = 20000;
	localparam int HSST_PER_US_0 = 10000;
	localparam int HSST_PER_US_1 = 20000;
	localparam int HSST_PER_US_2 = 50000;
	localparam int HSST_PER_US_3 = 100000;
	localparam int HSST_PER_US_4 = 200000;
	localparam int HSST_PER_US_5 = 1000000;
	localparam int HSST_PER_US_6 = 2000000;

	// Timer B configuration as held in its control register.
	typedef struct packed {
		logic [2:0] on_code;
		logic [2:0] per_code;
	} hsst_tcfg_type;

	// Synchronised supply fault levels.
	typedef struct packed {
		logic ov;
		logic uv;
	} hsst_supply_type;

	// On-time of a running code, in base ticks.
	function automatic logic [HSST_CNT_W-1:0] hsst_on_ticks(input logic [2:0] code);
		int us;
		case (code)
			3'h1: us = HSST_ON_US_1;
			3'h2: us = HSST_ON_US_2;
			3'h3: us = HSST_ON_US_3;
			3'h4: us = HSST_ON_US_4;
			3'h5: us = HSST_ON_US_5;
			default: us = 0;
		endcase
		return HSST_CNT_W'(us / HSST_TICK_US);
	endfunction : hsst_on_ticks

	// Period of a period code, in base ticks.
	function automatic logic [HSST_CNT_W-1:0] hsst_per_ticks(input logic [2:0] code);
		int us;
		case (code)
			3'h0: us = HSST_PER_US_0;
			3'h1: us = HSST_PER_US_1;
			3'h2: us = HSST_PER_US_2;
			3'h3: us = HSST_PER_US_3;
			3'h4: us = HSST_PER_US_4;
			3'h5: us = HSST_PER_US_5;
			3'h6: us = HSST_PER_US_6;
			default: us = HSST_PER_US_0;
		endcase
		return HSST_CNT_W'(us / HSST_TICK_US);
	endfunction : hsst_per_ticks

	// True when the configuration lets the timer run.
	function automatic logic hsst_running(input hsst_tcfg_type cfg);
		return (cfg.on_code != HSST_ON_LOW) && (cfg.on_code != HSST_ON_HIGH) &&
			(cfg.on_code != HSST_ON_RSVD) && (cfg.per_code != HSST_PER_RSVD);
	endfunction : hsst_running

endpackage : hsst_pkg

// *** hsst_sync.sv ***
// Three-stage synchroniser that passes a change once the last two stages agree.
`timescale 1ns/1ps
module hsst_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q_r
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Each bit takes a new level only when two settled stages agree.
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!resetn) begin
					q_r[i] <= 1'b0;
				end else if (s2_r[i] == s3_r[i]) begin
					q_r[i] <= s3_r[i];
				end
			end
		end
	endgenerate
endmodule : hsst_sync

// *** hsst_timer_b.sv ***
// Timer B: base tick divider, period counter and pulse output.
`timescale 1ns/1ps
module hsst_timer_b import hsst_pkg::*; #(
	parameter int TICK_CYCLES = HSST_TICK_CYC
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic          start,
	input  wire hsst_tcfg_type cfg,
	output logic               out_r
);
	logic [HSST_DIV_W-1:0] div_r;
	logic [HSST_CNT_W-1:0] cnt_r;
	logic [HSST_CNT_W-1:0] cnt_nxt;
	logic                  tick;
	logic                  running;

	assign tick = (div_r == HSST_DIV_W'(TICK_CYCLES - 1));
	assign running = hsst_running(cfg);

	// Base tick divider, realigned on every start.
	always_ff @(posedge clk) begin
		if (!resetn || start) begin
			div_r <= '0;
		end else if (tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// Next period position; wraps at the end of the selected period.
	always_comb begin
		cnt_nxt = cnt_r;
		if (start || !running) begin
			cnt_nxt = '0;
		end else if (tick) begin
			if (cnt_r >= hsst_per_ticks(cfg.per_code) - 1'b1) begin
				cnt_nxt = '0;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
	end

	// Period counter.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Output: high for the on-time at the start of each period, fixed when stopped.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_r <= 1'b0;
		end else if (cfg.on_code == HSST_ON_HIGH) begin
			out_r <= 1'b1;
		end else if (!running) begin
			out_r <= 1'b0;
		end else begin
			out_r <= (cnt_nxt < hsst_on_ticks(cfg.on_code));
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_low_stop;
		cfg.on_code == HSST_ON_LOW |=> !out_r;
	endproperty
	a_low_stop: assert property (p_low_stop) else $error("Stopped low timer drives high.");

	property p_high_stop;
		cfg.on_code == HSST_ON_HIGH |=> out_r;
	endproperty
	a_high_stop: assert property (p_high_stop) else $error("Stopped high timer drives low.");

	property p_on_len;
		running && $stable(cfg) && $fell(out_r) |-> cnt_r == hsst_on_ticks(cfg.on_code);
	endproperty
	a_on_len: assert property (p_on_len) else $error("Pulse ended at wrong tick.");

	property p_period;
		running && !start && $stable(cfg) |-> cnt_r < hsst_per_ticks(cfg.per_code);
	endproperty
	a_period: assert property (p_period) else $error("Counter passed period.");

	property p_start_on;
		start && running |=> out_r && cnt_r == '0;
	endproperty
	a_start_on: assert property (p_start_on) else $error("Start did not open pulse.");

	c_pulse_end: cover property (running && $fell(out_r));
endmodule : hsst_timer_b

// *** hsst_ctrl.sv ***
// Top of the high-side switch timer control block: registers, sources and shutdown.
`timescale 1ns/1ps
module hsst_ctrl import hsst_pkg::*; #(
	parameter int TICK_CYCLES = HSST_TICK_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RESETN,
	input  wire logic       SOFT_RESET,
	input  wire logic       RESTART,
	input  wire logic       CYCLIC_SENSE,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [6:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic [3:0] OVERCURRENT,
	input  wire logic [3:0] OVERTEMP,
	input  wire logic       SUPPLY_OV,
	input  wire logic       SUPPLY_UV,
	input  wire logic       TIMER_A_IN,
	input  wire logic       PWM_A_IN,
	input  wire logic       PWM_B_IN,
	output logic      [3:0] SWITCH_ON,
	output logic            SHUTDOWN_ACTIVE
);
	localparam int NSW = 4;

	hsst_tcfg_type         tcfg_r;
	logic                  ov_dis_r;
	logic                  uv_dis_r;
	logic                  rec_r;
	logic [NSW-1:0][2:0]   src_r;
	logic                  start_r;
	logic                  timer_b_out;
	logic [NSW-1:0]        oc_s;
	logic [NSW-1:0]        ot_s;
	hsst_supply_type       sup_s;
	logic                  fault_act;
	logic                  fault_prev_r;
	logic                  fault_release;
	logic                  wr_timer;
	logic                  wr_shut;
	logic [1:0]            wr_cfg;
	logic                  por;

	// Pick the selected source level for one switch.
	function automatic logic src_level(input logic [2:0] src, input logic tb);
		case (src)
			HSST_SRC_ON: return 1'b1;
			HSST_SRC_TIMER_A: return TIMER_A_IN;
			HSST_SRC_TIMER_B: return tb;
			HSST_SRC_PWM_A: return PWM_A_IN;
			HSST_SRC_PWM_B: return PWM_B_IN;
			default: return 1'b0;
		endcase
	endfunction : src_level

	// Fault inputs arrive from analogue comparators and are synchronised.
	hsst_sync #(
		.W (2 * NSW + 2)
	) u_sync (
		.clk    (CLK),
		.resetn (RESETN),
		.d      ({OVERCURRENT, OVERTEMP, SUPPLY_OV, SUPPLY_UV}),
		.q_r    ({oc_s, ot_s, sup_s})
	);

	// Timer B pulse generator.
	hsst_timer_b #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer_b (
		.clk    (CLK),
		.resetn (RESETN),
		.start  (start_r),
		.cfg    (tcfg_r),
		.out_r  (timer_b_out)
	);

	// Write decode and the power-on or soft reset condition.
	assign por = !RESETN || SOFT_RESET;
	assign wr_timer = REG_WR && (REG_ADDR == HSST_ADDR_TIMER_B);
	assign wr_shut = REG_WR && (REG_ADDR == HSST_ADDR_SHUTDOWN);
	assign wr_cfg[0] = REG_WR && (REG_ADDR == HSST_ADDR_CONFIG_1);
	assign wr_cfg[1] = REG_WR && (REG_ADDR == HSST_ADDR_CONFIG_2);

	// Shutdown applies when a supply fault is present and its shutdown is enabled.
	assign fault_act = (sup_s.ov && !ov_dis_r) || (sup_s.uv && !uv_dis_r);
	assign fault_release = fault_prev_r && !fault_act;

	// Timer B control register.
	always_ff @(posedge CLK) begin
		if (por) begin
			tcfg_r <= '0;
		end else if (RESTART && CYCLIC_SENSE) begin
			tcfg_r <= '0;
		end else if (wr_timer) begin
			tcfg_r.on_code <= REG_WDATA[HSST_HI_LSB +: 3];
			tcfg_r.per_code <= REG_WDATA[HSST_LO_LSB +: 3];
		end
	end

	// A write to the timer register restarts the timer once the new value has settled.
	always_ff @(posedge CLK) begin
		if (por) begin
			start_r <= 1'b0;
		end else begin
			start_r <= wr_timer && !(RESTART && CYCLIC_SENSE);
		end
	end

	// Shutdown control register; restart keeps the three control bits.
	always_ff @(posedge CLK) begin
		if (por) begin
			ov_dis_r <= 1'b0;
			uv_dis_r <= 1'b0;
			rec_r <= 1'b0;
		end else if (RESTART) begin
			ov_dis_r <= ov_dis_r;
			uv_dis_r <= uv_dis_r;
			rec_r <= rec_r;
		end else if (wr_shut) begin
			ov_dis_r <= REG_WDATA[HSST_BIT_OV_DIS];
			uv_dis_r <= REG_WDATA[HSST_BIT_UV_DIS];
			rec_r <= REG_WDATA[HSST_BIT_REC];
		end
	end

	// Fault history used to find the end of a supply fault.
	always_ff @(posedge CLK) begin
		if (por) begin
			fault_prev_r <= 1'b0;
		end else begin
			fault_prev_r <= fault_act;
		end
	end

	// Switch source fields; hardware clears take priority over software writes.
	genvar i;
	generate
		for (i = 0; i < NSW; i++) begin : g_sw
			localparam int LSB = (i % 2 == 0) ? HSST_LO_LSB : HSST_HI_LSB;
			always_ff @(posedge CLK) begin
				if (por || RESTART) begin
					src_r[i] <= HSST_FIELD_RESET;
				end else if (oc_s[i] || ot_s[i]) begin
					src_r[i] <= HSST_FIELD_RESET;
				end else if (fault_release && !rec_r) begin
					src_r[i] <= HSST_FIELD_RESET;
				end else if (wr_cfg[i/2]) begin
					src_r[i] <= REG_WDATA[LSB +: 3];
				end
			end

			// Switch drive: forced off during shutdown, otherwise the chosen source.
			always_ff @(posedge CLK) begin
				if (por) begin
					SWITCH_ON[i] <= 1'b0;
				end else begin
					SWITCH_ON[i] <= !fault_act && src_level(src_r[i], timer_b_out);
				end
			end
		end
	endgenerate

	// Shutdown indication.
	always_ff @(posedge CLK) begin
		if (por) begin
			SHUTDOWN_ACTIVE <= 1'b0;
		end else begin
			SHUTDOWN_ACTIVE <= fault_act;
		end
	end

	// Read data are captured on a read strobe; reserved and unmapped bits are zero.
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			REG_RDATA <= HSST_RESET_VALUE;
		end else if (REG_RD) begin
			case (REG_ADDR)
				HSST_ADDR_TIMER_B: REG_RDATA <= {1'b0, tcfg_r.on_code, 1'b0, tcfg_r.per_code};
				HSST_ADDR_SHUTDOWN: REG_RDATA <= {1'b0, ov_dis_r, uv_dis_r, rec_r, 4'h0};
				HSST_ADDR_CONFIG_1: REG_RDATA <= {1'b0, src_r[1], 1'b0, src_r[0]};
				HSST_ADDR_CONFIG_2: REG_RDATA <= {1'b0, src_r[3], 1'b0, src_r[2]};
				default: REG_RDATA <= HSST_RESET_VALUE;
			endcase
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	property p_tcfg_wr;
		wr_timer && !SOFT_RESET && !(RESTART && CYCLIC_SENSE)
			|=> tcfg_r.on_code == $past(REG_WDATA[HSST_HI_LSB +: 3])
			&& tcfg_r.per_code == $past(REG_WDATA[HSST_LO_LSB +: 3]);
	endproperty
	a_tcfg_wr: assert property (p_tcfg_wr) else $error("Timer B fields not stored.");

	property p_start;
		wr_timer && !SOFT_RESET && !(RESTART && CYCLIC_SENSE) |=> start_r;
	endproperty
	a_start: assert property (p_start) else $error("Timer write did not start timer.");

	property p_restart_tmr;
		RESTART && CYCLIC_SENSE |=> tcfg_r == '0;
	endproperty
	a_restart_tmr: assert property (p_restart_tmr) else $error("Restart kept timer B.");

	property p_rsvd;
		REG_RD |=> !REG_RDATA[7] && !REG_RDATA[3];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("Reserved bit read as one.");

	property p_ov_off;
		sup_s.ov && !ov_dis_r && !SOFT_RESET |=> SWITCH_ON == '0 ##0 SHUTDOWN_ACTIVE;
	endproperty
	a_ov_off: assert property (p_ov_off) else $error("Overvoltage left a switch on.");

	property p_uv_off;
		sup_s.uv && !uv_dis_r && !SOFT_RESET |=> SWITCH_ON == '0;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("Undervoltage left a switch on.");

	property p_norec;
		fault_release && !rec_r |=> src_r == '0;
	endproperty
	a_norec: assert property (p_norec) else $error("Switches kept without recovery.");

	property p_rec;
		fault_release && rec_r && !SOFT_RESET && !RESTART && oc_s == '0 && ot_s == '0
			&& wr_cfg == '0
			|=> src_r == $past(src_r);
	endproperty
	a_rec: assert property (p_rec) else $error("Recovery lost switch state.");

	property p_restart_sd;
		RESTART && !SOFT_RESET |=> $stable({ov_dis_r, uv_dis_r, rec_r});
	endproperty
	a_restart_sd: assert property (p_restart_sd) else $error("Restart changed shutdown bits.");

	property p_src_on;
		src_r[0] == HSST_SRC_ON && !fault_act && !SOFT_RESET |=> SWITCH_ON[0];
	endproperty
	a_src_on: assert property (p_src_on) else $error("Source on did not drive switch.");

	property p_oc_clear;
		oc_s[2] || ot_s[2] |=> src_r[2] == HSST_FIELD_RESET;
	endproperty
	a_oc_clear: assert property (p_oc_clear) else $error("Overload did not clear source.");

	property p_cfg1_wr;
		wr_cfg[0] && !SOFT_RESET && !RESTART && !oc_s[1] && !ot_s[1] && !fault_release
			|=> src_r[1] == $past(REG_WDATA[HSST_HI_LSB +: 3]);
	endproperty
	a_cfg1_wr: assert property (p_cfg1_wr) else $error("Switch two source not stored.");

	// Reset clears, read-back, supply shutdown, source decoding and source writes.
	property p_soft_clr;
		SOFT_RESET |=> src_r == '0 && tcfg_r == '0 && !ov_dis_r && !uv_dis_r && !rec_r;
	endproperty
	a_soft_clr: assert property (p_soft_clr) else $error("Soft reset kept a field.");

	property p_restart_src;
		RESTART && !SOFT_RESET |=> src_r == '0;
	endproperty
	a_restart_src: assert property (p_restart_src) else $error("Restart kept a source.");

	property p_sd_rsvd;
		REG_RD && REG_ADDR == HSST_ADDR_SHUTDOWN |=> REG_RDATA[HSST_BIT_REC-1:0] == '0;
	endproperty
	a_sd_rsvd: assert property (p_sd_rsvd) else $error("Low shutdown bits not zero.");

	property p_timer_rd;
		REG_RD && REG_ADDR == HSST_ADDR_TIMER_B
			|=> REG_RDATA[HSST_HI_LSB +: 3] == $past(tcfg_r.on_code);
	endproperty
	a_timer_rd: assert property (p_timer_rd) else $error("On-time read back wrong.");

	property p_ov_dis;
		sup_s.ov && ov_dis_r && !(sup_s.uv && !uv_dis_r) |=> !SHUTDOWN_ACTIVE;
	endproperty
	a_ov_dis: assert property (p_ov_dis) else $error("Disabled overvoltage shut down.");

	property p_uv_dis;
		sup_s.uv && uv_dis_r && !(sup_s.ov && !ov_dis_r) |=> !SHUTDOWN_ACTIVE;
	endproperty
	a_uv_dis: assert property (p_uv_dis) else $error("Disabled undervoltage shut down.");

	property p_shut_all;
		fault_act && !SOFT_RESET |=> SWITCH_ON == '0 && SHUTDOWN_ACTIVE;
	endproperty
	a_shut_all: assert property (p_shut_all) else $error("Supply fault left a switch on.");

	property p_sw_timer_b;
		src_r[0] == HSST_SRC_TIMER_B && !fault_act && !SOFT_RESET
			|=> SWITCH_ON[0] == $past(timer_b_out);
	endproperty
	a_sw_timer_b: assert property (p_sw_timer_b) else $error("Switch missed timer B.");

	property p_rsvd_src;
		src_r[3] > HSST_SRC_PWM_B |=> !SWITCH_ON[3];
	endproperty
	a_rsvd_src: assert property (p_rsvd_src) else $error("Reserved source drove a switch.");

	property p_cfg2_wr;
		wr_cfg[1] && !SOFT_RESET && !RESTART && !oc_s[2] && !ot_s[2]
			&& !(fault_release && !rec_r)
			|=> src_r[2] == $past(REG_WDATA[HSST_LO_LSB +: 3]);
	endproperty
	a_cfg2_wr: assert property (p_cfg2_wr) else $error("Switch three source not stored.");

	c_timer_b_sw: cover property (src_r[0] == HSST_SRC_TIMER_B && SWITCH_ON[0]);
	c_recover: cover property (fault_release && rec_r);
	c_overload: cover property (oc_s[0] && src_r[0] != HSST_FIELD_RESET);
	c_cyclic_restart: cover property (RESTART && CYCLIC_SENSE && tcfg_r != '0);
endmodule : hsst_ctrl

// *** hsst_load_model.sv ***
// Behavioural model of the four high-side loads that report overload back to the block.
`timescale 1ns/1ps
module hsst_load_model (
	input  wire logic       clk,
	input  wire logic [3:0] switch_on,
	input  wire logic [3:0] short_req,
	input  wire logic [3:0] hot_req,
	output logic      [3:0] overcurrent,
	output logic      [3:0] overtemp
);
	// A shorted load only draws overcurrent while its switch really drives it.
	always_ff @(posedge clk) begin
		overcurrent <= switch_on & short_req;
	end

	// Overtemperature follows the heating request, whatever the switch does.
	always_ff @(posedge clk) begin
		overtemp <= hot_req;
	end
endmodule : hsst_load_model

// *** tb.sv ***
// Self-checking testbench of the high-side switch timer control block.
`timescale 1ns/1ps
module tb import hsst_pkg::*;;
	localparam int TK = 2;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       soft_reset = 1'b0;
	logic       restart = 1'b0;
	logic       cyclic_sense = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [3:0] overcurrent;
	logic [3:0] overtemp;
	logic [3:0] short_req = 4'h0;
	logic [3:0] hot_req = 4'h0;
	logic       supply_ov = 1'b0;
	logic       supply_uv = 1'b0;
	logic       timer_a_in = 1'b0;
	logic       pwm_a_in = 1'b0;
	logic       pwm_b_in = 1'b0;
	logic [3:0] switch_on;
	logic       shutdown_active;
	int         n_mismatch = 0;
	int         checks_done = 0;
	logic [7:0] stop_cfg [4] = '{8'h00, 8'h60, 8'h70, 8'h17};
	logic       stop_exp [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int         hi_us [4] = '{100, 300, 1000, 10000};
	int         per_us [4] = '{10000, 20000, 50000, 100000};
	logic [7:0] sd_cfg [5] = '{8'h10, 8'h10, 8'h40, 8'h20, 8'h00};
	logic       ov_t [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic       on_t [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

	// Free-running clock of 8 ns.
	always #4 clk = ~clk;

	hsst_ctrl #(.TICK_CYCLES(TK)) i_dut (.CLK(clk), .RESETN(resetn), .SOFT_RESET(soft_reset),
		.RESTART(restart), .CYCLIC_SENSE(cyclic_sense), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.OVERCURRENT(overcurrent), .OVERTEMP(overtemp), .SUPPLY_OV(supply_ov),
		.SUPPLY_UV(supply_uv), .TIMER_A_IN(timer_a_in), .PWM_A_IN(pwm_a_in),
		.PWM_B_IN(pwm_b_in), .SWITCH_ON(switch_on), .SHUTDOWN_ACTIVE(shutdown_active));

	hsst_load_model i_load (.clk(clk), .switch_on(switch_on), .short_req(short_req),
		.hot_req(hot_req), .overcurrent(overcurrent), .overtemp(overtemp));

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Waits n edges, then lets their updates land.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// One register write cycle.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// One register read cycle, compared with the expected byte.
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd_chk

	// Restart pulse with the cyclic sense level held for the same cycle.
	task automatic do_restart(input logic cs);
		@(posedge clk);
		cyclic_sense <= cs;
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		cyclic_sense <= 1'b0;
		tick(2);
	endtask : do_restart

	// Runs timer B from a stopped state and measures its first pulse and period.
	task automatic measure(input logic [7:0] cfg, input int hi_e, input int per_e);
		int n;
		int h;
		int l;
		wr(HSST_ADDR_TIMER_B, 8'h00);
		tick(3);
		wr(HSST_ADDR_TIMER_B, cfg);
		n = 0;
		while (switch_on[0] !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		check(n, 2);
		h = 0;
		while (switch_on[0] === 1'b1 && h < 50000) begin
			tick(1);
			h++;
		end
		l = 0;
		while (switch_on[0] === 1'b0 && l < 50000) begin
			tick(1);
			l++;
		end
		check((h >= hi_e - 1) && (h <= hi_e + 1), 1);
		check((h + l >= per_e - 1) && (h + l <= per_e + 1), 1);
	endtask : measure

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// Source code of each loop step and what the switch must show for it.
	function automatic logic src_exp(input logic [2:0] c);
		case (c)
			3'h1: return 1'b1;
			3'h2: return timer_a_in;
			3'h3: return 1'b1;
			3'h4: return pwm_a_in;
			3'h5: return pwm_b_in;
			default: return 1'b0;
		endcase
	endfunction : src_exp

	// Cuts a hang short.
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	// Main sequence of tests.
	initial begin
		logic       e;
		logic       k;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd_chk(HSST_ADDR_TIMER_B, 8'h00);
		rd_chk(HSST_ADDR_SHUTDOWN, 8'h00);
		rd_chk(HSST_ADDR_CONFIG_1, 8'h00);
		rd_chk(HSST_ADDR_CONFIG_2, 8'h00);
		wr(HSST_ADDR_TIMER_B, 8'hFF);
		rd_chk(HSST_ADDR_TIMER_B, 8'h77);
		wr(HSST_ADDR_SHUTDOWN, 8'hFF);
		rd_chk(HSST_ADDR_SHUTDOWN, 8'h70);
		wr(HSST_ADDR_CONFIG_1, 8'hFF);
		rd_chk(HSST_ADDR_CONFIG_1, 8'h77);
		wr(HSST_ADDR_CONFIG_2, 8'hFF);
		rd_chk(HSST_ADDR_CONFIG_2, 8'h77);
		rd_chk(7'h7F, 8'h00);
		// Restart keeps timer B without cyclic sense and clears it with it.
		do_restart(1'b0);
		rd_chk(HSST_ADDR_TIMER_B, 8'h77);
		rd_chk(HSST_ADDR_SHUTDOWN, 8'h70);
		rd_chk(HSST_ADDR_CONFIG_1, 8'h00);
		do_restart(1'b1);
		rd_chk(HSST_ADDR_TIMER_B, 8'h00);
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
		rd_chk(HSST_ADDR_SHUTDOWN, 8'h00);
		// Every source code on all switches, switch 3 or switch 4 idle in turn.
		wr(HSST_ADDR_TIMER_B, 8'h60);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk);
			timer_a_in <= (p == 0);
			pwm_a_in <= (p == 0);
			pwm_b_in <= (p != 0);
			for (int c = 0; c < 8; c++) begin
				wr(HSST_ADDR_CONFIG_1, {1'b0, 3'(c), 1'b0, 3'(c)});
				wr(HSST_ADDR_CONFIG_2, (p == 0) ? {1'b0, 3'(c), 4'h0} : {5'h00, 3'(c)});
				tick(2);
				e = src_exp(3'(c));
				check(switch_on, (p == 0) ? {e, 1'b0, e, e} : {1'b0, e, e, e});
			end
		end
		// Stopped timer codes on a switch fed by timer B.
		wr(HSST_ADDR_CONFIG_2, 8'h00);
		wr(HSST_ADDR_CONFIG_1, 8'h03);
		for (int i = 0; i < 4; i++) begin
			wr(HSST_ADDR_TIMER_B, stop_cfg[i]);
			tick(4);
			check(switch_on[0], stop_exp[i]);
		end
		// Running timer pulses and periods.
		for (int i = 0; i < 4; i++)
			measure({1'b0, 3'(i + 1), 1'b0, 3'(i)}, hi_us[i] / HSST_TICK_US * TK,
				per_us[i] / HSST_TICK_US * TK);
		measure(8'h52, HSST_ON_US_5 / HSST_TICK_US * TK, HSST_PER_US_2 / HSST_TICK_US * TK);
		// Overload clears the affected source fields.
		wr(HSST_ADDR_TIMER_B, 8'h00);
		wr(HSST_ADDR_CONFIG_1, 8'h11);
		tick(2);
		@(posedge clk);
		short_req <= 4'h1;
		tick(10);
		rd_chk(HSST_ADDR_CONFIG_1, 8'h10);
		check(switch_on, 4'h2);
		@(posedge clk);
		hot_req <= 4'h2;
		tick(10);
		rd_chk(HSST_ADDR_CONFIG_1, 8'h00);
		@(posedge clk);
		short_req <= 4'h0;
		hot_req <= 4'h0;
		tick(8);
		// Supply faults with recovery set, with each disable bit alone and with no shutdown bit set.
		for (int i = 0; i < 5; i++) begin
			wr(HSST_ADDR_CONFIG_1, 8'h01);
			wr(HSST_ADDR_SHUTDOWN, sd_cfg[i]);
			@(posedge clk);
			supply_ov <= ov_t[i];
			supply_uv <= !ov_t[i];
			tick(8);
			check(switch_on[0], on_t[i]);
			check(shutdown_active, !on_t[i]);
			@(posedge clk);
			supply_ov <= 1'b0;
			supply_uv <= 1'b0;
			tick(8);
			k = on_t[i] | sd_cfg[i][HSST_BIT_REC];
			check(switch_on[0], k);
			rd_chk(HSST_ADDR_CONFIG_1, {7'h00, k});
		end
		print_verdict();
	end
endmodule : tb
